//--- shared/sim_pkg.sv
// Purpose: constants and types of the switch interrupt flags and masks
// Assumes: apb slave, 32-bit data, word-aligned registers
// Notes: register index times four gives the byte address
package sim_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int NPORT = 5;
  localparam int NLINK = 4;
  // register indexes
  localparam logic [7:0] IDX_INT_STATUS = 8'h7C;
  localparam logic [7:0] IDX_INT_MASK = 8'h7D;
  localparam logic [7:0] IDX_ACL_STATUS = 8'h7E;
  localparam logic [7:0] IDX_ACL_ENABLE = 8'h7F;
  localparam logic [1:0] ADDR_LSB = 2'h0;
  // status and mask field positions
  localparam int BIT_WAKE = 4;
  localparam int LINK_HI = 3;
  localparam int LINK_LO = 0;
  localparam int ACL_HI = 4;
  localparam logic [4:0] FLAG_RST = 5'h00;
  localparam logic [REG_W-1:0] REG_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

  typedef struct packed {
    logic wake;
    logic [NLINK-1:0] link;
  } sim_flags_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic err;
    logic [REG_W-1:0] wdata;
  } sim_access_t;
endpackage

//--- logic/sim_irq_regs.sv
// Purpose: interrupt flags, enables and request of a five-port switch
// Assumes: apb slave on pclk, one wait state per access
// Notes: register index times four gives the byte address
//
// Summary of operation
// [R1] port two link change sets status bit 1
// [R2] port one link change sets status bit 0
// [R3] link flags stay set until software writes one there; reset zero
// [R4] mask bit 4 is read-write wake interrupt enable, resets zero
// [R5] mask bits 3..0 are read-write link interrupt enables, reset zero
// [R6] acl status shows one read-only event flag per port in bits 4..0
// [R7] acl control holds one read-write enable per port in bits 4..0
// [R8] bits 7..5 of mask and acl registers read zero and ignore writes
// [R9] wake event sets status bit 4; cleared by wake control clear or by software writing one there
// [R10] ports four and three link changes set status bits 3 and 2
// [R11] interrupt request is high while any enabled flag is set
// [R12] an event in the clear cycle keeps its flag set
`timescale 1ns/100ps
module sim_irq_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sim_pkg::ADDR_W-1:0] paddr,
  input wire logic [sim_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [sim_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [sim_pkg::NLINK-1:0] link_change,
  input wire logic power_wake_event,
  input wire logic power_wake_clear,
  input wire logic [sim_pkg::NPORT-1:0] acl_event_pulse,
  input wire logic [sim_pkg::NPORT-1:0] acl_event_clear,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // sticky flag update: set beats clear
  function automatic logic [4:0] sticky(
    input logic [4:0] cur,
    input logic [4:0] set,
    input logic [4:0] clr
  );
    sticky = set | (cur & ~clr);
  endfunction

  function automatic logic [sim_pkg::ADDR_W-1:0] reg_addr(
    input logic [7:0] idx
  );
    reg_addr = {2'h0, idx, sim_pkg::ADDR_LSB};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  sim_pkg::sim_flags_t int_status;
  sim_pkg::sim_flags_t interrupt_enable_mask;
  logic [sim_pkg::NPORT-1:0] acl_event_flags;
  logic [sim_pkg::NPORT-1:0] acl_event_enables;

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  wire access = psel & penable & ~pready;
  wire done = psel & penable & pready;
  wire sel_stat = paddr == reg_addr(sim_pkg::IDX_INT_STATUS);
  wire sel_mask = paddr == reg_addr(sim_pkg::IDX_INT_MASK);
  wire sel_aclst = paddr == reg_addr(sim_pkg::IDX_ACL_STATUS);
  wire sel_aclen = paddr == reg_addr(sim_pkg::IDX_ACL_ENABLE);
  wire mapped = sel_stat | sel_mask | sel_aclst | sel_aclen;
  wire lane0 = pstrb[0];
  wire [sim_pkg::REG_W-1:0] wbyte = pwdata[sim_pkg::REG_W-1:0];

  sim_pkg::sim_access_t acc;
  assign acc.rd = done & ~pwrite & mapped;
  assign acc.wr = done & pwrite & mapped & lane0;
  assign acc.err = ~mapped;
  assign acc.wdata = wbyte;

  wire wr_stat = acc.wr & sel_stat;
  wire wr_mask = acc.wr & sel_mask;
  wire wr_aclen = acc.wr & sel_aclen;

  ////////////////////////////////////////////////////////////////////////
  // flag next values

  wire [4:0] stat_set = {power_wake_event, link_change}; // R1 R2 R10 R9
  wire [4:0] stat_clr = {
    power_wake_clear | (wr_stat & acc.wdata[sim_pkg::BIT_WAKE]),
    {sim_pkg::NLINK{wr_stat}} & acc.wdata[sim_pkg::LINK_HI:0]
  }; // R3 R9
  wire [4:0] next_status = sticky(int_status, stat_set, stat_clr); // R12
  wire [4:0] next_acl =
    sticky(acl_event_flags, acl_event_pulse, acl_event_clear); // R6 R12

  wire [4:0] pend_stat = int_status & interrupt_enable_mask;
  wire [4:0] pend_acl = acl_event_flags & acl_event_enables;
  wire next_irq = (|pend_stat) | (|pend_acl); // R11

  ////////////////////////////////////////////////////////////////////////
  // read mux, upper bits zero

  wire [sim_pkg::REG_W-1:0] rd_byte =
    sel_stat ? {3'h0, int_status} :
    sel_mask ? {3'h0, interrupt_enable_mask} : // R8
    sel_aclst ? {3'h0, acl_event_flags} : // R8
    sel_aclen ? {3'h0, acl_event_enables} : // R8
    sim_pkg::REG_ZERO;
  wire [sim_pkg::DATA_W-1:0] next_prdata =
    {24'h000000, rd_byte};

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= sim_pkg::FLAG_RST; // R3
      acl_event_flags <= sim_pkg::FLAG_RST;
    end else begin
      int_status <= next_status; // R1 R2 R10
      acl_event_flags <= next_acl; // R6
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_mask <= sim_pkg::FLAG_RST; // R4 R5
    end else if (wr_mask) begin
      interrupt_enable_mask <= acc.wdata[sim_pkg::BIT_WAKE:0]; // R4 R5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acl_event_enables <= sim_pkg::FLAG_RST; // R7
    end else if (wr_aclen) begin
      acl_event_enables <= acc.wdata[sim_pkg::ACL_HI:0]; // R7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= sim_pkg::DATA_ZERO;
    end else begin
      pready <= access;
      pslverr <= access & acc.err;
      if (access) begin
        prdata <= pwrite ? sim_pkg::DATA_ZERO : next_prdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_link1_set: assert property (@(posedge pclk) disable iff (!presetn) // R1
    link_change[1] |=> int_status.link[1])
    else $error("port two link flag not set");

  a_link_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (!int_status.link[1] && !link_change[1]) |=> !int_status.link[1])
    else $error("port two link flag set with no change");

  a_link0_set: assert property (@(posedge pclk) disable iff (!presetn) // R2
    link_change[0] |=> int_status.link[0])
    else $error("port one link flag not set");

  a_link_hold: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (int_status.link[3] && !(wr_stat && acc.wdata[3]))
    |=> int_status.link[3])
    else $error("link flag dropped without a clear");

  a_link_w1c: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (wr_stat && acc.wdata[2] && !link_change[2])
    |=> !int_status.link[2])
    else $error("link flag not cleared by write one");

  a_mask_wake: assert property (@(posedge pclk) disable iff (!presetn) // R4
    wr_mask |=> interrupt_enable_mask.wake
      == $past(pwdata[sim_pkg::BIT_WAKE]))
    else $error("wake enable not written");

  a_mask_hold: assert property (@(posedge pclk) disable iff (!presetn) // R4
    !wr_mask |=> $stable(interrupt_enable_mask.wake))
    else $error("wake enable changed without a write");

  a_mask_link: assert property (@(posedge pclk) disable iff (!presetn) // R5
    !wr_mask |=> $stable(interrupt_enable_mask.link))
    else $error("link enables changed without a write");

  a_strobe_skip: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (done && pwrite && sel_mask && !lane0)
    |=> $stable(interrupt_enable_mask))
    else $error("mask written with lane zero off");

  a_acl_flag: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (acl_event_pulse[4] ##1 !acl_event_clear[4])
    |=> acl_event_flags[4])
    else $error("acl flag not held");

  a_acl_set: assert property (@(posedge pclk) disable iff (!presetn) // R6
    acl_event_pulse[0] |=> acl_event_flags[0])
    else $error("acl flag not set");

  a_acl_ro: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (done && pwrite && sel_aclst && !(|acl_event_pulse)
      && !(|acl_event_clear))
    |=> $stable(acl_event_flags))
    else $error("acl flags changed by a bus write");

  a_acl_clear: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (acl_event_clear[0] && !acl_event_pulse[0]) |=> !acl_event_flags[0])
    else $error("acl flag not cleared");

  a_acl_enable: assert property (@(posedge pclk) disable iff (!presetn) // R7
    wr_aclen |=> acl_event_enables == $past(pwdata[4:0]))
    else $error("acl enables not written");

  a_acl_en_hold: assert property (@(posedge pclk) disable iff (!presetn) // R7
    !wr_aclen |=> $stable(acl_event_enables))
    else $error("acl enables changed without a write");

  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (access && !pwrite && (sel_mask || sel_aclen))
    |=> prdata[7:5] == 3'h0)
    else $error("reserved bits read nonzero");

  a_read_upper: assert property (@(posedge pclk) disable iff (!presetn) // R8
    acc.rd |-> prdata[sim_pkg::DATA_W-1:sim_pkg::REG_W] == 24'h000000)
    else $error("read data upper bytes nonzero");

  a_wake_set: assert property (@(posedge pclk) disable iff (!presetn) // R9
    power_wake_event |=> int_status.wake)
    else $error("wake flag not set");

  a_wake_hold: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (int_status.wake && !power_wake_clear
      && !(wr_stat && acc.wdata[sim_pkg::BIT_WAKE]))
    |=> int_status.wake)
    else $error("wake flag dropped without a clear");

  a_wake_clear: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (power_wake_clear && !power_wake_event) |=> !int_status.wake)
    else $error("wake flag not cleared");

  a_link3_set: assert property (@(posedge pclk) disable iff (!presetn) // R10
    link_change[3] ##1 1'b1 |-> int_status.link[3])
    else $error("port four link flag not set");

  a_link2_set: assert property (@(posedge pclk) disable iff (!presetn) // R10
    link_change[2] |=> int_status.link[2])
    else $error("port three link flag not set");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // R11
    ((|pend_stat) || (|pend_acl)) |=> irq)
    else $error("irq missing while enabled flag set");

  a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (pend_stat == 5'h00 && pend_acl == 5'h00) |=> !irq)
    else $error("irq high with no enabled flag");

  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (link_change[0] && wr_stat && acc.wdata[0])
    |=> int_status.link[0])
    else $error("event lost to a clear");

  a_wake_wins: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (power_wake_event && power_wake_clear) |=> int_status.wake)
    else $error("wake event lost to a clear");

  a_acl_wins: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (acl_event_pulse[2] && acl_event_clear[2]) |=> acl_event_flags[2])
    else $error("acl event lost to a clear");

  // bus handshake: one wait state, one-cycle answer, error only with ready
  a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("apb answer late");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready high two cycles");

  a_err_pair: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error flag without ready");

  a_err_read: assert property (@(posedge pclk) disable iff (!presetn)
    (access && acc.err && !pwrite) |=> prdata == sim_pkg::DATA_ZERO)
    else $error("unmapped read returned data");

endmodule

//--- verification/tb_sim_irq_regs.sv
// Purpose: self-checking bench of the switch interrupt flags and masks
// Assumes: apb master on pclk, registers at index times four
// Notes: a reference model of flags and enables is checked at every read
`timescale 1ns/100ps
module tb_sim_irq_regs;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] lnk = 4'h0;
  logic wk = 1'b0;
  logic wk_clr = 1'b0;
  logic [4:0] acl = 5'h00;
  logic [4:0] acl_clr = 5'h00;
  logic irq;
  logic [7:0] st, mk, as, ae;
  logic [31:0] r, d, q;
  logic e;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;

  sim_irq_regs i_sim_irq_regs (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_change(lnk), .power_wake_event(wk),
    .power_wake_clear(wk_clr), .acl_event_pulse(acl),
    .acl_event_clear(acl_clr), .irq(irq));

  always #12.5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [7:0] i, input logic [7:0] x);
    apb(1'b0, i, 32'h00000000);
    cmp(r, {24'h000000, x});
    cmp({31'h00000000, e}, 32'h00000000);
    cmp({31'h00000000, irq}, {31'h00000000, |(st & mk) | |(as & ae)});
  endtask

  task automatic chkall();
    chk(sim_pkg::IDX_INT_STATUS, st);
    chk(sim_pkg::IDX_INT_MASK, mk);
    chk(sim_pkg::IDX_ACL_STATUS, as);
    chk(sim_pkg::IDX_ACL_ENABLE, ae);
  endtask

  // one-cycle event and clear pulses; a set beats a clear
  task automatic ev(input logic [3:0] l, input logic w, input logic [4:0] a,
                    input logic wc, input logic [4:0] ac);
    @(posedge pclk);
    lnk <= l;
    wk <= w;
    acl <= a;
    wk_clr <= wc;
    acl_clr <= ac;
    @(posedge pclk);
    lnk <= 4'h0;
    wk <= 1'b0;
    acl <= 5'h00;
    wk_clr <= 1'b0;
    acl_clr <= 5'h00;
    st[4] = (st[4] & ~wc) | w;
    st[3:0] = st[3:0] | l;
    as[4:0] = (as[4:0] & ~ac) | a;
  endtask

  task automatic wr_en(input logic [31:0] m, input logic [31:0] a);
    apb(1'b1, sim_pkg::IDX_INT_MASK, m);
    mk = {3'h0, m[4:0]};
    apb(1'b1, sim_pkg::IDX_ACL_ENABLE, a);
    ae = {3'h0, a[4:0]};
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(56552));
    {st, mk, as, ae} = 32'h00000000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chkall();
    apb(1'b0, 8'h7B, 32'hFFFFFFFF);
    cmp({31'h00000000, e}, 32'h00000001);
    cmp(r, 32'h00000000);
    $display("test reset done");
    repeat (4) begin
      wr_en($urandom(), $urandom());
      apb(1'b1, sim_pkg::IDX_ACL_STATUS, $urandom());
      chkall();
    end
    pstrb <= 4'hE;
    apb(1'b1, sim_pkg::IDX_INT_MASK, 32'h000000FF);
    pstrb <= 4'hF;
    chkall();
    $display("test access done");
    for (int k = 0; k < 5; k++) begin
      d = 32'h00000001 << k;
      q = $urandom();
      ev(d[3:0], d[4], q[4:0], 1'b0, 5'h00);
      chkall();
    end
    $display("test events done");
    wr_en(32'h0000001F, 32'h0000001F);
    chkall();
    d = $urandom();
    apb(1'b1, sim_pkg::IDX_INT_STATUS, d);
    st[4:0] = st[4:0] & ~d[4:0];
    chkall();
    apb(1'b1, sim_pkg::IDX_INT_STATUS, 32'h000000FF);
    st = 8'h00;
    chkall();
    lnk <= 4'hF;
    wk <= 1'b1;
    apb(1'b1, sim_pkg::IDX_INT_STATUS, 32'h000000FF);
    lnk <= 4'h0;
    wk <= 1'b0;
    st = 8'h1F;
    chkall();
    ev(4'h0, 1'b1, 5'h15, 1'b1, 5'h1F);
    chkall();
    ev(4'h0, 1'b0, 5'h00, 1'b1, 5'h1F);
    chkall();
    wr_en(32'h00000000, 32'h00000000);
    chkall();
    $display("test clears done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {st, mk, as, ae} = 32'h00000000;
    chkall();
    $display("test rerun reset done");
    tally_and_finish();
  end
endmodule
